/* File: logic/data_memory_address_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_consts.vh"

module data_memory_address_gen #(
    parameter RAM_DEPTH = `RAM_BYTES
) (
    input wire clk_i,
    input wire rstn_i,
    input wire cmd_valid_i,
    input wire [`CMD_W-1:0] cmd_i,
    input wire [`MODE_W-1:0] mode_i,
    input wire [7:0] op1_i,
    input wire [7:0] op2_i,
    input wire [7:0] a_i,
    input wire [7:0] x_i,
    input wire [7:0] y_i,
    input wire carry_i,
    input wire [7:0] psw_i,
    input wire [15:0] pc_i,
    input wire [7:0] wdata_i,
    input wire [7:0] ext_rdata_i,
    output wire cmd_ready_o,
    output wire done_o,
    output wire [7:0] rdata_o,
    output wire [15:0] target_o,
    output wire [7:0] psw_o,
    output wire psw_load_o,
    output wire x_inc_o,
    output wire [7:0] x_next_o,
    output wire page_flag_o,
    output wire [7:0] page_select_o,
    output wire [7:0] sp_o,
    output wire [15:0] ext_addr_o,
    output wire [7:0] ext_wdata_o,
    output wire ext_we_o,
    output wire ext_re_o,
    output wire periph_sel_o
);
    localparam S_IDLE = 5'b00001, S_PTRL = 5'b00010, S_PTRH = 5'b00100, S_DATA = 5'b01000, S_STK = 5'b10000;
    reg [4:0] state;
    reg [15:0] mem_addr, target_q;
    reg [`MODE_W-1:0] mode_q;
    reg [`CMD_W-1:0] cmd_q;
    reg [7:0] mem_wdata, y_q, ptr_lo, rdata_q, psw_q, x_next_q, page_sel;
    reg [1:0] stk_k, stk_last;
    reg mem_we, is_push, done_q, psw_load_q, x_inc_q, page_flag;
    // direct-page address: the page byte comes from page select only when the flag is set
    function [15:0] dp_addr;
        input flag;
        input [7:0] page;
        input [7:0] offset;
        begin
            dp_addr = flag ? {page, offset} : {`ZERO_PAGE, offset};
        end
    endfunction
    // the next pointer byte stays in the same page for direct-page pointers
    function [15:0] ptr_next;
        input [15:0] addr;
        input wrap_in_page;
        begin
            ptr_next = wrap_in_page ? {addr[15:8], addr[7:0] + 8'h01} : addr + 16'h0001;
        end
    endfunction
    wire [7:0] sp, pop_addr, ram_q;
    wire idle = (state == S_IDLE);
    wire accept = idle && cmd_valid_i;
    wire access = !idle;
    wire [7:0] off_x = op1_i + x_i;
    wire [7:0] off_y = op1_i + y_i;
    wire [15:0] abs_addr = {op2_i, op1_i};
    wire ram_hit = (mem_addr < `RAM_END);
    wire page_hit = (mem_addr == `PAGE_SEL_ADDR);
    wire ctrl_hit = (mem_addr >= `CTRL_FIRST) && (mem_addr <= `CTRL_LAST);
    wire ext_hit = !ram_hit && !page_hit;
    wire ram_we = access && mem_we && ram_hit;
    // unmapped control addresses simply return whatever the external side drives
    wire [7:0] mem_rdata = ram_hit ? ram_q : (page_hit ? page_sel : ext_rdata_i);
    wire accept_push = accept && ((cmd_i == `CMD_CALL) || (cmd_i == `CMD_INTR));
    wire accept_pop = accept && ((cmd_i == `CMD_RET) || (cmd_i == `CMD_INTERRUPT_RETURN_INSTR));
    wire stk_more = (state == S_STK) && (stk_k != stk_last);
    wire push_now = accept_push || (stk_more && is_push);
    wire pop_now = accept_pop || (stk_more && !is_push);
    wire [1:0] next_k = idle ? 2'h0 : stk_k + 2'h1;
    wire [1:0] pop_kind = stk_last - stk_k;
    wire [7:0] psw_push = (psw_i & ~`PSW_G_MASK) | (page_flag ? `PSW_G_MASK : 8'h00);
    wire is_ind = (mode_i == `MODE_IND_X) || (mode_i == `MODE_IND_Y) ||
        (mode_i == `MODE_IND_DP) || (mode_i == `MODE_IND_ABS);
    reg [15:0] ea;
    reg [7:0] reg_val, push_byte;
    always @* begin
        case (mode_i)
            `MODE_DP: ea = dp_addr(page_flag, page_sel, op1_i);
            `MODE_ABS: ea = abs_addr;
            `MODE_DPX_INC: ea = dp_addr(page_flag, page_sel, x_i);
            `MODE_DPX: ea = dp_addr(page_flag, page_sel, x_i);
            `MODE_DP_X: ea = dp_addr(page_flag, page_sel, off_x);
            `MODE_DP_Y: ea = dp_addr(page_flag, page_sel, off_y);
            `MODE_ABS_Y: ea = abs_addr + {8'h00, y_i};
            `MODE_IND_X: ea = dp_addr(page_flag, page_sel, off_x);
            `MODE_IND_Y: ea = dp_addr(page_flag, page_sel, op1_i);
            `MODE_IND_DP: ea = dp_addr(page_flag, page_sel, op1_i);
            `MODE_IND_ABS: ea = abs_addr;
            default: ea = 16'h0000;
        endcase
    end
    always @* begin
        case (op1_i[2:0])
            `REG_A: reg_val = a_i;
            `REG_X: reg_val = x_i;
            `REG_Y: reg_val = y_i;
            `REG_C: reg_val = {7'h00, carry_i};
            `REG_PSW: reg_val = psw_push;
            default: reg_val = 8'h00;
        endcase
    end
    always @* begin
        case (next_k)
            `STK_PCH: push_byte = pc_i[15:8];
            `STK_PCL: push_byte = pc_i[7:0];
            default: push_byte = psw_push;
        endcase
    end
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= S_IDLE;
            mem_addr <= 16'h0000;
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            mode_q <= `MODE_REG;
            cmd_q <= `CMD_READ;
            y_q <= 8'h00;
            ptr_lo <= 8'h00;
            stk_k <= 2'h0;
            stk_last <= 2'h0;
            is_push <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
            target_q <= 16'h0000;
            psw_q <= `PSW_RESET;
            psw_load_q <= 1'b0;
            x_inc_q <= 1'b0;
            x_next_q <= 8'h00;
            page_flag <= 1'b0;
            page_sel <= `PAGE_SEL_RESET;
        end else begin
            done_q <= 1'b0;
            psw_load_q <= 1'b0;
            x_inc_q <= 1'b0;
            // a page select write lands at this edge, so only later commands see it
            if (access && mem_we && page_hit) begin
                page_sel <= mem_wdata;
            end
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        cmd_q <= cmd_i;
                        mode_q <= mode_i;
                        y_q <= y_i;
                        mem_we <= 1'b0;
                        case (cmd_i)
                            `CMD_SET_PAGE_FLAG_INSTR, `CMD_CLEAR_PAGE_FLAG_INSTR, `CMD_LDSP: begin
                                done_q <= 1'b1;
                                if (cmd_i != `CMD_LDSP) begin
                                    page_flag <= (cmd_i == `CMD_SET_PAGE_FLAG_INSTR);
                                end
                            end
                            `CMD_CALL, `CMD_INTR: begin
                                // return address goes out before the target is handed back
                                is_push <= 1'b1;
                                stk_k <= 2'h0;
                                stk_last <= (cmd_i == `CMD_INTR) ? `STK_LAST_INTR : `STK_LAST_CALL;
                                mem_addr <= {`ZERO_PAGE, sp};
                                mem_we <= 1'b1;
                                mem_wdata <= push_byte;
                                state <= S_STK;
                            end
                            `CMD_RET, `CMD_INTERRUPT_RETURN_INSTR: begin
                                is_push <= 1'b0;
                                stk_k <= 2'h0;
                                stk_last <= (cmd_i == `CMD_INTERRUPT_RETURN_INSTR) ? `STK_LAST_INTR : `STK_LAST_CALL;
                                mem_addr <= {`ZERO_PAGE, pop_addr};
                                state <= S_STK;
                            end
                            default: begin
                                if (mode_i == `MODE_REG) begin
                                    rdata_q <= reg_val;
                                    done_q <= 1'b1;
                                end else if (mode_i == `MODE_IMM) begin
                                    rdata_q <= op1_i;
                                    done_q <= 1'b1;
                                end else if (is_ind) begin
                                    mem_addr <= ea;
                                    state <= S_PTRL;
                                end else if (cmd_i == `CMD_JUMP) begin
                                    target_q <= ea;
                                    done_q <= 1'b1;
                                end else begin
                                    mem_addr <= ea;
                                    mem_we <= (cmd_i == `CMD_WRITE);
                                    mem_wdata <= wdata_i;
                                    state <= S_DATA;
                                end
                                if (mode_i == `MODE_DPX_INC) begin
                                    x_inc_q <= 1'b1;
                                    x_next_q <= x_i + 8'h01;
                                end
                            end
                        endcase
                    end
                end
                S_PTRL: begin
                    ptr_lo <= mem_rdata;
                    mem_addr <= ptr_next(mem_addr, mode_q != `MODE_IND_ABS);
                    state <= S_PTRH;
                end
                S_PTRH: begin
                    if ((cmd_q == `CMD_JUMP) || (mode_q == `MODE_IND_DP) || (mode_q == `MODE_IND_ABS)) begin
                        target_q <= {mem_rdata, ptr_lo};
                        done_q <= 1'b1;
                        state <= S_IDLE;
                    end else begin
                        if (mode_q == `MODE_IND_Y) begin
                            mem_addr <= {mem_rdata, ptr_lo} + {8'h00, y_q};
                        end else begin
                            mem_addr <= {mem_rdata, ptr_lo};
                        end
                        mem_we <= (cmd_q == `CMD_WRITE);
                        state <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (!mem_we) begin
                        rdata_q <= mem_rdata;
                    end
                    mem_we <= 1'b0;
                    done_q <= 1'b1;
                    state <= S_IDLE;
                end
                S_STK: begin
                    if (!is_push) begin
                        case (pop_kind)
                            `STK_PCH: target_q[15:8] <= mem_rdata;
                            `STK_PCL: target_q[7:0] <= mem_rdata;
                            default: begin
                                psw_q <= mem_rdata;
                                psw_load_q <= 1'b1;
                                page_flag <= mem_rdata[`PSW_G_BIT];
                            end
                        endcase
                    end
                    if (stk_more) begin
                        stk_k <= next_k;
                        mem_addr <= {`ZERO_PAGE, is_push ? sp : pop_addr};
                        mem_wdata <= push_byte;
                    end else begin
                        if (is_push) begin
                            target_q <= pc_i;
                        end
                        mem_we <= 1'b0;
                        done_q <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                    mem_we <= 1'b0;
                end
            endcase
        end
    end
    user_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(8)
    ) u_ram (
        .clk_i(clk_i),
        .we_i(ram_we),
        .addr_i(mem_addr[7:0]),
        .wdata_i(mem_wdata),
        .rdata_o(ram_q)
    );
    stack_unit #(
        .W(8)
    ) u_stack (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .load_i(accept && (cmd_i == `CMD_LDSP)),
        .load_val_i(wdata_i),
        .push_i(push_now),
        .pop_i(pop_now),
        .sp_o(sp),
        .pop_addr_o(pop_addr)
    );
    assign cmd_ready_o = idle;
    assign done_o = done_q;
    assign rdata_o = rdata_q;
    assign target_o = target_q;
    assign psw_o = psw_q;
    assign psw_load_o = psw_load_q;
    assign x_inc_o = x_inc_q;
    assign x_next_o = x_next_q;
    assign page_flag_o = page_flag;
    assign page_select_o = page_sel;
    assign sp_o = sp;
    assign ext_addr_o = mem_addr;
    assign ext_wdata_o = mem_wdata;
    assign ext_we_o = access && mem_we && ext_hit;
    assign ext_re_o = access && !mem_we && ext_hit;
    // peripheral registers live only in the control window
    assign periph_sel_o = access && ext_hit && ctrl_hit;
endmodule // data_memory_address_gen

`default_nettype wire

/* File: logic/addr_gen_consts.vh */
`ifndef ADDR_GEN_CONSTS_VH
`define ADDR_GEN_CONSTS_VH

// operand addressing modes
`define MODE_W 4
`define MODE_REG 4'h0
`define MODE_IMM 4'h1
`define MODE_DP 4'h2
`define MODE_ABS 4'h3
`define MODE_DPX_INC 4'h4
`define MODE_DPX 4'h5
`define MODE_DP_X 4'h6
`define MODE_DP_Y 4'h7
`define MODE_ABS_Y 4'h8
`define MODE_IND_X 4'h9
`define MODE_IND_Y 4'hA
`define MODE_IND_DP 4'hB
`define MODE_IND_ABS 4'hC

// sequencer commands
`define CMD_W 4
`define CMD_READ 4'h0
`define CMD_WRITE 4'h1
`define CMD_JUMP 4'h2
`define CMD_CALL 4'h3
`define CMD_INTR 4'h4
`define CMD_RET 4'h5
`define CMD_INTERRUPT_RETURN_INSTR 4'h6
`define CMD_SET_PAGE_FLAG_INSTR 4'h7
`define CMD_CLEAR_PAGE_FLAG_INSTR 4'h8
`define CMD_LDSP 4'h9

// register-mode selectors
`define REG_A 3'h0
`define REG_X 3'h1
`define REG_Y 3'h2
`define REG_C 3'h3
`define REG_PSW 3'h4

// data memory map
`define RAM_BYTES 192
`define RAM_END 16'h00C0
`define CTRL_FIRST 16'h00C0
`define CTRL_LAST 16'h00FF
`define PAGE_SEL_ADDR 16'h00F3
`define PAGE_SEL_RESET 8'h00
`define ZERO_PAGE 8'h00

// status word and stack
`define PSW_G_BIT 5
`define PSW_G_MASK 8'h20
`define PSW_RESET 8'h00
`define SP_RESET 8'h00
`define STK_PCH 2'h0
`define STK_PCL 2'h1
`define STK_PSW 2'h2
`define STK_LAST_CALL 2'h1
`define STK_LAST_INTR 2'h2

`endif

/* File: logic/user_ram.v */
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_consts.vh"

module user_ram #(
    parameter DEPTH = `RAM_BYTES,
    parameter AW = 8
) (
    input wire clk_i,
    input wire we_i,
    input wire [AW-1:0] addr_i,
    input wire [7:0] wdata_i,
    output wire [7:0] rdata_o
);
    reg [7:0] mem [0:DEPTH-1];
    wire in_range = ({1'b0, addr_i} < DEPTH);

    always @(posedge clk_i) begin
        if (we_i && in_range) begin
            mem[addr_i] <= wdata_i;
        end
    end

    assign rdata_o = in_range ? mem[addr_i] : 8'h00;
endmodule // user_ram

`default_nettype wire

/* File: logic/stack_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_consts.vh"

module stack_unit #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rstn_i,
    input wire load_i,
    input wire [W-1:0] load_val_i,
    input wire push_i,
    input wire pop_i,
    output wire [W-1:0] sp_o,
    output wire [W-1:0] pop_addr_o
);
    reg [W-1:0] sp;

    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp <= `SP_RESET;
        end else if (load_i) begin
            sp <= load_val_i;
        end else if (push_i) begin
            sp <= sp - {{(W-1){1'b0}}, 1'b1};
        end else if (pop_i) begin
            sp <= pop_addr_o;
        end
    end

    assign sp_o = sp;
    // restore reads one above, so the pointer always marks the next free slot
    assign pop_addr_o = sp + {{(W-1){1'b0}}, 1'b1};
endmodule // stack_unit

`default_nettype wire

/* File: bench/periph_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module periph_bus_model (
    input wire logic clk_i,
    input wire logic [15:0] ext_addr_i,
    input wire logic [7:0] ext_wdata_i,
    input wire logic ext_we_i,
    input wire logic ext_re_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    initial begin
        // unwritten places answer with a junk pattern
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5A;
    end
    // released bus shows the inverse of the last byte, not a stale copy
    always_comb rdata_o = ext_re_i ? mem[ext_addr_i] : ~last;
    always @(posedge clk_i) begin
        if (ext_we_i) begin
            mem[ext_addr_i] <= ext_wdata_i;
        end
        if (ext_re_i) begin
            last <= mem[ext_addr_i];
        end
    end
endmodule // periph_bus_model
`default_nettype wire

/* File: bench/addr_gen_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_consts.vh"
module addr_gen_chk (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_i,
    input wire logic [3:0] mode_i,
    input wire logic [7:0] op1_i,
    input wire logic [7:0] op2_i,
    input wire logic [7:0] x_i,
    input wire logic cmd_ready_o,
    input wire logic done_o,
    input wire logic [7:0] rdata_o,
    input wire logic psw_load_o,
    input wire logic x_inc_o,
    input wire logic [7:0] x_next_o,
    input wire logic page_flag_o,
    input wire logic [7:0] page_select_o,
    input wire logic [7:0] sp_o,
    input wire logic [15:0] ext_addr_o,
    input wire logic periph_sel_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire acc = cmd_valid_i && cmd_ready_o;
    wire rw = acc && (cmd_i == `CMD_READ || cmd_i == `CMD_WRITE);
    property p_flag_instr;
        acc && (cmd_i == `CMD_SET_PAGE_FLAG_INSTR || cmd_i == `CMD_CLEAR_PAGE_FLAG_INSTR) |=> done_o && page_flag_o == ($past(cmd_i) == `CMD_SET_PAGE_FLAG_INSTR);
    endproperty
    a_flag_instr: assert property (p_flag_instr) else $error("page flag instruction wrong");
    property p_dp_zero;
        rw && mode_i == `MODE_DP && !page_flag_o |=> ext_addr_o == {8'h00, $past(op1_i)};
    endproperty
    a_dp_zero: assert property (p_dp_zero) else $error("direct page left page zero");
    property p_dp_page;
        rw && mode_i == `MODE_DP && page_flag_o |=> ext_addr_o == {$past(page_select_o), $past(op1_i)};
    endproperty
    a_dp_page: assert property (p_dp_page) else $error("paged address wrong");
    property p_abs;
        rw && mode_i == `MODE_ABS |=> ext_addr_o == {$past(op2_i), $past(op1_i)};
    endproperty
    a_abs: assert property (p_abs) else $error("absolute address wrong");
    property p_dp_x;
        rw && mode_i == `MODE_DP_X && !page_flag_o |=> ext_addr_o == {8'h00, $past(op1_i) + $past(x_i)};
    endproperty
    a_dp_x: assert property (p_dp_x) else $error("indexed address left page");
    property p_x_inc;
        rw && mode_i == `MODE_DPX_INC |=> x_inc_o && x_next_o == $past(x_i) + 8'h01;
    endproperty
    a_x_inc: assert property (p_x_inc) else $error("index increment wrong");
    property p_imm;
        acc && cmd_i == `CMD_READ && mode_i == `MODE_IMM |=> done_o && rdata_o == $past(op1_i);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate operand wrong");
    property p_call;
        acc && cmd_i == `CMD_CALL |-> ##3 done_o && sp_o == $past(sp_o, 3) - 8'h02;
    endproperty
    a_call: assert property (p_call) else $error("call stack pointer wrong");
    property p_intr;
        acc && cmd_i == `CMD_INTR |-> ##4 done_o && sp_o == $past(sp_o, 4) - 8'h03;
    endproperty
    a_intr: assert property (p_intr) else $error("interrupt stack pointer wrong");
    property p_ret;
        acc && cmd_i == `CMD_RET |-> ##1 (!psw_load_o) [*3] ##0 (done_o && sp_o == $past(sp_o, 3) + 8'h02);
    endproperty
    a_ret: assert property (p_ret) else $error("return restored flags");
    property p_interrupt_return_instr;
        acc && cmd_i == `CMD_INTERRUPT_RETURN_INSTR |-> ##[1:4] psw_load_o;
    endproperty
    a_interrupt_return_instr: assert property (p_interrupt_return_instr) else $error("interrupt return kept flags");
    property p_periph;
        periph_sel_o |-> ext_addr_o >= `CTRL_FIRST && ext_addr_o <= `CTRL_LAST;
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral select outside window");
    c_interrupt_return_instr: cover property (acc && cmd_i == `CMD_INTERRUPT_RETURN_INSTR);
    c_periph: cover property (periph_sel_o);
    c_ind_y: cover property (rw && mode_i == `MODE_IND_Y);
endmodule // addr_gen_chk
bind data_memory_address_gen addr_gen_chk chk (.*);
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "addr_gen_consts.vh"
module testbench;
    logic clk_i = 1'b0, rstn_i = 1'b0, cmd_valid_i = 1'b0, carry_i = 1'b0, nc = 1'b1;
    logic [3:0] cmd_i = 4'h0, mode_i = 4'h0;
    logic [7:0] op1_i = 8'h00, op2_i = 8'h00, a_i = 8'h00, x_i = 8'h00, y_i = 8'h00;
    logic [7:0] psw_i = 8'h00, wdata_i = 8'h00, na = 8'h11, nx = 8'h22, ny = 8'h33, npsw = 8'h83;
    logic [15:0] pc_i = 16'h0000, npc = 16'h0000;
    logic [7:0] regv [5] = '{8'h11, 8'h22, 8'h33, 8'h01, 8'h83};
    wire cmd_ready_o, done_o, psw_load_o, x_inc_o, page_flag_o, ext_we_o, ext_re_o, periph_sel_o;
    wire [7:0] rdata_o, psw_o, x_next_o, page_select_o, sp_o, ext_wdata_o, ext_rdata_i;
    wire [15:0] target_o, ext_addr_o;
    integer fail_count = 0, n_tests = 0;
    data_memory_address_gen uut (.*);
    periph_bus_model far (.clk_i(clk_i), .ext_addr_i(ext_addr_o), .ext_wdata_i(ext_wdata_o),
        .ext_we_i(ext_we_o), .ext_re_i(ext_re_o), .rdata_o(ext_rdata_i));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task stop_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task automatic chk(input [15:0] got, input [15:0] exp);
        begin
            n_tests++;
            if (got !== exp) begin
                fail_count++;
                $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one request, held until the accepting edge, then wait for done
    task automatic op(input [3:0] c, input [3:0] m, input [7:0] o1, input [7:0] o2, input [7:0] w);
        integer k;
        begin
            @(posedge clk_i);
            cmd_i <= c; mode_i <= m; op1_i <= o1; op2_i <= o2; wdata_i <= w;
            a_i <= na; x_i <= nx; y_i <= ny; carry_i <= nc; psw_i <= npsw; pc_i <= npc;
            cmd_valid_i <= 1'b1;
            @(posedge clk_i);
            cmd_valid_i <= 1'b0;
            k = 0;
            @(negedge clk_i);
            while (done_o !== 1'b1 && k < 20) begin
                @(negedge clk_i);
                k++;
            end
            if (done_o !== 1'b1) begin
                fail_count++;
                $display("CHECK FAILED t=%0t no completion", $time);
                stop_test;
            end
        end
    endtask
    task automatic rd(input [3:0] m, input [7:0] o1, input [7:0] o2, input [7:0] exp);
        begin
            op(`CMD_READ, m, o1, o2, 8'h00);
            chk(rdata_o, exp);
        end
    endtask
    task automatic jp(input [3:0] m, input [7:0] o1, input [7:0] o2, input [15:0] exp);
        begin
            op(`CMD_JUMP, m, o1, o2, 8'h00);
            chk(target_o, exp);
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(negedge clk_i);
        chk(page_select_o, `PAGE_SEL_RESET);
        chk(page_flag_o, 1'b0);
        op(`CMD_WRITE, `MODE_DP, 8'h35, 8'h00, 8'h55);
        op(`CMD_WRITE, `MODE_DP, 8'hBF, 8'h00, 8'h3C);
        op(`CMD_WRITE, `MODE_DP, 8'hC8, 8'h00, 8'h5A);
        rd(`MODE_DP, 8'h35, 8'h00, 8'h55);
        rd(`MODE_DP, 8'hBF, 8'h00, 8'h3C);
        rd(`MODE_DP, 8'hC8, 8'h00, 8'h5A);
        $display("test memory map done");
        for (int i = 0; i < 5; i++) rd(`MODE_REG, 8'(i), 8'h00, regv[i]);
        rd(`MODE_IMM, 8'h35, 8'h00, 8'h35);
        nx = 8'h10;
        rd(`MODE_DP_X, 8'h25, 8'h00, 8'h55);
        nx = 8'hF5;
        rd(`MODE_DP_X, 8'h40, 8'h00, 8'h55);
        ny = 8'h05;
        rd(`MODE_DP_Y, 8'h30, 8'h00, 8'h55);
        rd(`MODE_ABS_Y, 8'h30, 8'h00, 8'h55);
        nx = 8'h35;
        rd(`MODE_DPX_INC, 8'h00, 8'h00, 8'h55);
        chk(x_next_o, 8'h36);
        rd(`MODE_DPX, 8'h00, 8'h00, 8'h55);
        op(`CMD_WRITE, `MODE_DP, 8'h20, 8'h00, 8'h35);
        op(`CMD_WRITE, `MODE_DP, 8'h21, 8'h00, 8'h00);
        op(`CMD_WRITE, `MODE_DP, 8'h36, 8'h00, 8'h66);
        nx = 8'h10;
        rd(`MODE_IND_X, 8'h10, 8'h00, 8'h55);
        ny = 8'h01;
        rd(`MODE_IND_Y, 8'h20, 8'h00, 8'h66);
        jp(`MODE_IND_DP, 8'h20, 8'h00, 16'h0035);
        jp(`MODE_IND_ABS, 8'h20, 8'h00, 16'h0035);
        $display("test operand modes done");
        op(`CMD_WRITE, `MODE_DP, 8'hF3, 8'h00, 8'h01);
        chk(page_select_o, 8'h01);
        rd(`MODE_DP, 8'hF3, 8'h00, 8'h01);
        op(`CMD_SET_PAGE_FLAG_INSTR, `MODE_REG, 8'h00, 8'h00, 8'h00);
        chk(page_flag_o, 1'b1);
        op(`CMD_WRITE, `MODE_DP, 8'h35, 8'h00, 8'hA5);
        rd(`MODE_DP, 8'h35, 8'h00, 8'hA5);
        rd(`MODE_ABS, 8'h35, 8'h00, 8'h55);
        op(`CMD_CLEAR_PAGE_FLAG_INSTR, `MODE_REG, 8'h00, 8'h00, 8'h00);
        rd(`MODE_DP, 8'h35, 8'h00, 8'h55);
        $display("test paging done");
        op(`CMD_LDSP, `MODE_REG, 8'h00, 8'h00, 8'hBF);
        chk(sp_o, 8'hBF);
        npc = 16'h1234;
        op(`CMD_CALL, `MODE_REG, 8'h00, 8'h00, 8'h00);
        chk(sp_o, 8'hBD);
        rd(`MODE_DP, 8'hBF, 8'h00, 8'h12);
        rd(`MODE_DP, 8'hBE, 8'h00, 8'h34);
        jp(`MODE_ABS, 8'h35, 8'hF0, 16'hF035);
        op(`CMD_RET, `MODE_REG, 8'h00, 8'h00, 8'h00);
        chk(target_o, 16'h1234);
        chk(sp_o, 8'hBF);
        npc = 16'hABCD;
        op(`CMD_INTR, `MODE_REG, 8'h00, 8'h00, 8'h00);
        chk(sp_o, 8'hBC);
        jp(`MODE_ABS, 8'h00, 8'h10, 16'h1000);
        op(`CMD_SET_PAGE_FLAG_INSTR, `MODE_REG, 8'h00, 8'h00, 8'h00);
        op(`CMD_INTERRUPT_RETURN_INSTR, `MODE_REG, 8'h00, 8'h00, 8'h00);
        chk(target_o, 16'hABCD);
        chk(psw_o, 8'h83);
        chk(page_flag_o, 1'b0);
        $display("test stack done");
        @(posedge clk_i);
        rstn_i <= 1'b0;
        @(negedge clk_i);
        chk(sp_o, `SP_RESET);
        chk(page_select_o, `PAGE_SEL_RESET);
        chk(psw_o, `PSW_RESET);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(`MODE_DP, 8'h35, 8'h00, 8'h55);
        $display("test reset done");
        stop_test;
    end
endmodule // testbench
`default_nettype wire
